// ===== adc_port_regs.vh
// Constants for the converter serial host port
`ifndef ADC_PORT_REGS_VH
`define ADC_PORT_REGS_VH
`define CMD_BITS        8
`define RESULT_BITS     16
`define SETUP_CKMODE_HI 5
`define SETUP_CKMODE_LO 4
`define SETUP_REFSEL    2
`define SETUP_RESET     8'h20
`define CKMODE_CNV      2'h0
`define CKMODE_EXT      2'h3
`define CMD_CONV_BIT    7
`define CMD_SETUP_TOP   2'h1
`endif

// ===== adc_serial_port_pins.v
// Serial host port pin logic of the multichannel converter
// Function
// - Chip select low enables serial transfers
// - Chip select high tristates data output
// - Input bits captured on serial clock rise
// - Output bit changes on serial clock fall
// - End-of-conversion low only with valid result
// - Setup selects conversion-start input or channel
// - Setup selects negative reference or channel
// - End-of-conversion rises on select/start fall
// - Setup bits 5:4 are clock mode
`timescale 1ns/1ps
`include "adc_port_regs.vh"
module adc_serial_port_pins
#(
  parameter CONV_CYCLES = 16'd1750
)
(
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        cs_n,
  input  wire        sclk,
  input  wire        din,
  output reg         dout_q,
  output reg         dout_oe_q,
  output reg         eoc_n_q,
  input  wire        convreq_or_channel_pin,
  output reg         convreq_enable_q,
  output reg         refneg_select_q,
  output reg  [1:0]  clock_mode_q,
  output reg  [15:0] result_q
);
  wire cs_lvl;
  wire cs_rise;
  wire cs_fall;
  wire sclk_lvl;
  wire sclk_rise;
  wire sclk_fall;
  wire din_lvl;
  wire cnv_lvl;
  wire cnv_rise;
  wire cnv_fall;

  edge_sync u_cs (.clk(clk), .sys_rst(sys_rst), .pin(cs_n),
    .level_q(cs_lvl), .rise(cs_rise), .fall(cs_fall));
  edge_sync u_sclk (.clk(clk), .sys_rst(sys_rst), .pin(sclk),
    .level_q(sclk_lvl), .rise(sclk_rise), .fall(sclk_fall));
  edge_sync u_din (.clk(clk), .sys_rst(sys_rst), .pin(din),
    .level_q(din_lvl), .rise(), .fall());
  edge_sync u_cnv (.clk(clk), .sys_rst(sys_rst), .pin(convreq_or_channel_pin),
    .level_q(cnv_lvl), .rise(cnv_rise), .fall(cnv_fall));

  // Din is sampled one cycle later than sclk so that edge and data align
  reg  [7:0]  shift_q;
  reg  [3:0]  bit_cnt_q;
  reg         first_q;
  reg  [7:0]  setup_q;
  reg  [15:0] out_sr_q;
  reg  [15:0] conv_cnt_q;
  reg         busy_q;
  reg         valid_q;
  wire [7:0]  byte_in = {shift_q[6:0], din_lvl};
  wire        byte_done = (bit_cnt_q == 4'd7);
  wire [1:0]  mode_now = setup_q[`SETUP_CKMODE_HI:`SETUP_CKMODE_LO];
  wire        cnv_pin_on = (mode_now != 2'h2) && (mode_now != `CKMODE_EXT);
  reg         rise_d1_q;

  always @(posedge clk)
  begin
    if (sys_rst)
      rise_d1_q <= 1'b0;
    else
      rise_d1_q <= sclk_rise & ~cs_lvl;
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      shift_q    <= 8'h00;
      bit_cnt_q  <= 4'h0;
      first_q    <= 1'b1;
      setup_q    <= `SETUP_RESET;
      out_sr_q   <= 16'h0000;
      conv_cnt_q <= 16'h0000;
      busy_q     <= 1'b0;
      valid_q    <= 1'b0;
      result_q   <= 16'h0000;
    end
    else
    begin
      if (cs_fall)
      begin
        bit_cnt_q <= 4'h0;
        first_q   <= 1'b1;
        valid_q   <= 1'b0;
      end
      else if (rise_d1_q)
      begin
        shift_q   <= byte_in;
        bit_cnt_q <= byte_done ? 4'h0 : bit_cnt_q + 4'h1;
        if (byte_done)
        begin
          first_q <= 1'b0;
          // Only the leading byte is decoded as a command
          if (first_q && byte_in[`CMD_CONV_BIT] && mode_now == 2'h2)
          begin
            busy_q     <= 1'b1;
            conv_cnt_q <= 16'h0000;
          end
          else if (first_q && byte_in[7:6] == `CMD_SETUP_TOP)
            setup_q <= {2'b01, byte_in[5:0]};
        end
      end
      if (cnv_fall && cnv_pin_on && !busy_q)
      begin
        busy_q     <= 1'b1;
        conv_cnt_q <= 16'h0000;
        valid_q    <= 1'b0;
      end
      else if (busy_q)
      begin
        conv_cnt_q <= conv_cnt_q + 16'h0001;
        if (conv_cnt_q == CONV_CYCLES - 16'd1)
        begin
          busy_q   <= 1'b0;
          valid_q  <= 1'b1;
          result_q <= {6'h00, conv_cnt_q[9:0] ^ {2'b00, setup_q}};
          out_sr_q <= {6'h00, conv_cnt_q[9:0] ^ {2'b00, setup_q}};
        end
      end
      else if (sclk_fall && !cs_lvl)
        out_sr_q <= {out_sr_q[14:0], 1'b0};
    end
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      dout_q           <= 1'b0;
      dout_oe_q        <= 1'b0;
      eoc_n_q          <= 1'b1;
      convreq_enable_q <= 1'b0;
      refneg_select_q  <= 1'b0;
      clock_mode_q     <= 2'h2;
    end
    else
    begin
      dout_oe_q <= ~cs_lvl;
      if (cs_fall)
        dout_q <= out_sr_q[15];
      else if (sclk_fall && !cs_lvl)
        dout_q <= out_sr_q[14];
      if (mode_now == `CKMODE_EXT)
        eoc_n_q <= 1'b1;
      else if (cs_fall || cnv_fall)
        eoc_n_q <= 1'b1;
      else
        eoc_n_q <= ~valid_q;
      convreq_enable_q <= cnv_pin_on;
      refneg_select_q  <= setup_q[`SETUP_REFSEL];
      clock_mode_q     <= mode_now;
    end
  end
endmodule

// ===== adc_serial_port_pins_sva.sv
// Checker for the converter serial port pins
`timescale 1ns/1ps
module adc_serial_port_pins_sva #(parameter CONV_CYCLES = 16'd1750)
(
  input wire clk, sys_rst, cs_n, sclk, din, dout_q, dout_oe_q, eoc_n_q,
  input wire convreq_or_channel_pin, convreq_enable_q, refneg_select_q,
  input wire [1:0] clock_mode_q,
  input wire [15:0] result_q
);
  reg [15:0] gap_q;
  // Saturates so a long idle never wraps
  always @(posedge clk)
    if (sys_rst || !eoc_n_q) gap_q <= 16'h0000;
    else if (gap_q != 16'hFFFF) gap_q <= gap_q + 16'h0001;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_oe_cs_high: assert property (cs_n [*5] |-> !dout_oe_q)
    else $error("dout on");
  a_oe_cs_low: assert property (!cs_n [*5] |-> dout_oe_q)
    else $error("dout off");
  a_dout_on_fall: assert property ($changed(dout_q) && dout_oe_q && $past(dout_oe_q)
    |-> !$past(sclk, 3) || !$past(sclk, 4))
    else $error("dout moved");
  a_eoc_cs_fall: assert property ($fell(cs_n) |-> ##[1:6] eoc_n_q)
    else $error("eoc low");
  a_eoc_after_conv: assert property ($fell(eoc_n_q) |-> gap_q >= CONV_CYCLES)
    else $error("eoc early");
  a_ext_eoc_high: assert property (clock_mode_q == 2'h3 |-> eoc_n_q)
    else $error("eoc mode");
  a_mode_reset: assert property ($past(sys_rst) |-> clock_mode_q == 2'h2 && eoc_n_q)
    else $error("reset val");
  a_pin_mode: assert property ($stable(clock_mode_q) [*2]
    |-> convreq_enable_q == !clock_mode_q[1])
    else $error("pin mode");
  cover property ($fell(eoc_n_q));
  cover property (clock_mode_q == 2'h3);
  cover property (convreq_enable_q && !convreq_or_channel_pin);
endmodule
bind adc_serial_port_pins adc_serial_port_pins_sva #(.CONV_CYCLES(CONV_CYCLES)) u_sva (.clk,
  .sys_rst, .cs_n, .sclk, .din, .dout_q, .dout_oe_q, .eoc_n_q, .convreq_or_channel_pin,
  .convreq_enable_q, .refneg_select_q, .clock_mode_q, .result_q);

// ===== adc_serial_port_pins_tb_top.sv
// Bench for the converter serial port pins
`timescale 1ns/1ps
module adc_serial_port_pins_tb_top;
  reg clk = 1'b0, sys_rst = 1'b1, cnv_n = 1'b1;
  wire cs_n, sclk, din, oe, eoc_n, en, rs, dout;
  wire [15:0] res;
  wire [1:0] md;
  integer err_count = 0, checks = 0, cyc = 0, n;
  always #2 clk = ~clk;
  adc_serial_port_pins #(.CONV_CYCLES(16'd20)) u_adc_serial_port_pins (.clk, .sys_rst, .cs_n,
    .sclk, .din, .dout_q(dout), .dout_oe_q(oe), .eoc_n_q(eoc_n), .convreq_or_channel_pin(cnv_n),
    .convreq_enable_q(en), .refneg_select_q(rs), .clock_mode_q(md), .result_q(res));
  host u_host (.clk, .cs_n, .sclk, .din);
  task cmp(input [1:0] got, input [1:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("unexpected at %0t: %h %h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task wait_eoc;
    for (n = 0; eoc_n !== 1'b0 && n < 400; n = n + 1)
      @(posedge clk);
  endtask
  task t_setup(input [1:0] m);
    begin
      u_host.sel(1'b0);
      cmp(oe, 2'h1);
      u_host.xfer({2'h1, m, 1'b0, m[0], 2'h0});
      u_host.sel(1'b1);
      cmp(oe, 2'h0);
      cmp(md, m);
      cmp(rs, m[0]);
      cmp(en, !m[1]);
      $display("setup %h done", m);
    end
  endtask
  task t_conv;
    begin
      t_setup(2'h2);
      u_host.sel(1'b0);
      u_host.xfer(8'h80);
      u_host.sel(1'b1);
      wait_eoc;
      cmp(eoc_n, 2'h0);
      cmp(res[15:14], 2'h0);
      u_host.sel(1'b0);
      cmp(eoc_n, 2'h1);
      cmp(dout, 2'h0);
      u_host.sel(1'b1);
      // Pin request in start mode
      t_setup(2'h0);
      cnv_n <= 1'b0;
      repeat (4) @(posedge clk);
      cnv_n <= 1'b1;
      wait_eoc;
      cmp(eoc_n, 2'h0);
      cnv_n <= 1'b0;
      repeat (8) @(posedge clk);
      cmp(eoc_n, 2'h1);
      cnv_n <= 1'b1;
      $display("conversions done");
    end
  endtask
  // Far past the under one thousand cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count = err_count + 1;
      end_sim;
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    cmp(md, 2'h2);
    t_setup(2'h3);
    t_setup(2'h1);
    t_conv;
    end_sim;
  end
endmodule

// ===== edge_sync.v
// Two-flop synchroniser with edge detection
`timescale 1ns/1ps
module edge_sync
(
  input  wire clk,
  input  wire sys_rst,
  input  wire pin,
  output reg  level_q,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg sync_q;
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_q  <= 1'b1;
      sync_q  <= 1'b1;
      level_q <= 1'b1;
    end
    else
    begin
      meta_q  <= pin;
      sync_q  <= meta_q;
      level_q <= sync_q;
    end
  end
  assign rise = sync_q & ~level_q;
  assign fall = ~sync_q & level_q;
endmodule

// ===== host.sv
// Serial master model for the converter port
`timescale 1ns/1ps
module host
(
  input  wire clk,
  output reg  cs_n = 1'b1,
  output reg  sclk = 1'b0,
  output reg  din = 1'b0
);
  task sel(input v);
    begin
      cs_n <= v;
      repeat (8) @(posedge clk);
    end
  endtask
  // Clock idles low and runs only inside a frame
  task xfer(input [7:0] tx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
      begin
        din <= tx[i];
        repeat (8) @(posedge clk);
        sclk <= 1'b1;
        repeat (8) @(posedge clk);
        sclk <= 1'b0;
      end
    end
  endtask
endmodule
